// ### rtl/slu_pkg.sv
// Purpose: shared constants of the serial line unit
// Assumes: one 20 MHz clock; straps are static configuration levels
// Notes:   register offsets are byte offsets inside the four-word block
package slu_pkg;

    // clock
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int CLK_HZ_DEFAULT  = 1000000000 / CLOCK_PERIOD_NS;

    // register offsets within the block (address bits 2..0, bit 0 ignored)
    localparam logic [2:0] OFF_RX_STATUS = 3'h0;
    localparam logic [2:0] OFF_RX_BUFFER = 3'h2;
    localparam logic [2:0] OFF_TX_STATUS = 3'h4;
    localparam logic [2:0] OFF_TX_BUFFER = 3'h6;

    // field positions
    localparam int MODEM_BIT = 15;
    localparam int DONE_BIT  = 7;
    localparam int IE_BIT    = 6;
    localparam int RDR_BIT   = 0;
    localparam int BRK_BIT   = 0;
    localparam int VEC_TX_BIT = 2;

    // address decode: bits 15..13 must be ones (i/o page), bits 12..3 strapped
    localparam logic [2:0] IO_PAGE = 3'h7;

    // widths and reset values
    localparam int DIV_W      = 20;
    localparam int CHAR_W     = 8;
    localparam int SYNC_W     = 4;
    localparam int DIV_EXTRA  = 2;
    localparam logic RST_IE   = 1'b0;
    localparam logic RST_BRK  = 1'b0;
    localparam logic RST_DONE = 1'b0;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // stand-in rate for the external-rate strap codes
    localparam int EXT_BAUD = 9600;

    // rate-select strap code (1 = installed) to clock cycles per bit
    function automatic logic [DIV_W-1:0] bit_cycles(input logic [3:0] code,
                                                    input int clk_hz);
        int c;
        c = clk_hz / 110;
        unique case (code)
            4'h0: c = clk_hz / 110;
            4'hd: c = clk_hz / 50;
            4'hc: c = clk_hz / 75;
            4'hb: c = (clk_hz * 2) / 269;
            4'h1: c = clk_hz / 150;
            4'ha: c = clk_hz / 200;
            4'h2: c = clk_hz / 300;
            4'h9: c = clk_hz / 600;
            4'h4: c = clk_hz / 1200;
            4'h5: c = clk_hz / 1800;
            4'h8, 4'h3: c = clk_hz / 2400;
            4'h6: c = clk_hz / 4800;
            4'h7: c = clk_hz / 9600;
            4'he, 4'hf: c = clk_hz / EXT_BAUD;
        endcase
        if (c < DIV_EXTRA) c = DIV_EXTRA;
        return c[DIV_W-1:0];
    endfunction : bit_cycles

endpackage : slu_pkg

// ### rtl/char_buffer.sv
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: single clock, flush drops all entries
// Notes:   in_ready_o is low only when every entry is occupied
`timescale 1ns/1ns
`default_nettype none
module char_buffer
    import slu_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             ref_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             flush_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
            $error("char_buffer: DEPTH must be a power of two >= 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wptr;
        logic [PW-1:0]               rptr;
        logic [PW:0]                 count;
    } buf_state_t;

    buf_state_t st_r;
    buf_state_t st_nxt;
    logic       push;
    logic       pop;

    // handshakes are combinational from the occupancy count
    assign in_ready_o  = (st_r.count != (PW + 1)'(DEPTH));
    assign out_valid_o = (st_r.count != '0);
    assign out_data_o  = st_r.mem[st_r.rptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // pointer and count update
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wptr] = in_data_i;
            st_nxt.wptr = st_r.wptr + 1'b1;
        end
        if (pop) st_nxt.rptr = st_r.rptr + 1'b1;
        if (push && !pop) st_nxt.count = st_r.count + 1'b1;
        if (pop && !push) st_nxt.count = st_r.count - 1'b1;
        if (flush_i) begin
            st_nxt.wptr  = '0;
            st_nxt.rptr  = '0;
            st_nxt.count = '0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) st_r <= '0;
        else           st_r <= st_nxt;
    end
endmodule : char_buffer
`default_nettype wire

// ### rtl/serial_sender.sv
// Purpose: serialises one character: start, data lsb first, parity, stop bits
// Assumes: configuration is stable while a character is in flight
// Notes:   break holds the line at space; queued characters are still sent underneath it and lost
`timescale 1ns/1ns
`default_nettype none
module serial_sender
    import slu_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [DIV_W-1:0]  bit_cycles_i,
    input  wire logic [3:0]        data_bits_i,
    input  wire logic              parity_en_i,
    input  wire logic              parity_odd_i,
    input  wire logic              two_stop_i,
    input  wire logic              break_i,
    input  wire logic [CHAR_W-1:0] char_i,
    input  wire logic              char_valid_i,
    output logic                   char_ready_o,
    output logic                   txd_o
);
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_phase_t;

    typedef struct packed {
        tx_phase_t         phase;
        logic [DIV_W-1:0]  cnt;
        logic [3:0]        idx;
        logic [CHAR_W-1:0] shift;
        logic              par;
        logic              line;
    } tx_state_t;

    tx_state_t st_r;
    tx_state_t st_nxt;
    logic      bit_end;

    assign char_ready_o = (st_r.phase == TX_IDLE);
    assign bit_end      = (st_r.cnt == '0);
    assign txd_o        = st_r.line;

    // frame sequencer; break overrides the line level only
    always_comb begin
        st_nxt = st_r;
        if (st_r.phase != TX_IDLE) st_nxt.cnt = st_r.cnt - 1'b1;
        unique case (st_r.phase)
            TX_IDLE: if (char_valid_i) begin
                st_nxt.phase = TX_START;
                st_nxt.shift = char_i;
                st_nxt.par   = parity_odd_i;                 // RULE_13
                st_nxt.cnt   = bit_cycles_i - 1'b1;
                st_nxt.idx   = '0;
            end
            TX_START: if (bit_end) begin
                st_nxt.phase = TX_DATA;
                st_nxt.cnt   = bit_cycles_i - 1'b1;
            end
            TX_DATA: if (bit_end) begin
                st_nxt.par   = st_r.par ^ st_r.shift[0];
                st_nxt.shift = st_r.shift >> 1;              // RULE_20
                st_nxt.idx   = st_r.idx + 1'b1;
                st_nxt.cnt   = bit_cycles_i - 1'b1;
                if (st_r.idx + 1'b1 == data_bits_i)
                    st_nxt.phase = parity_en_i ? TX_PAR : TX_STOP;
            end
            TX_PAR: if (bit_end) begin
                st_nxt.phase = TX_STOP;
                st_nxt.idx   = '0;
                st_nxt.cnt   = bit_cycles_i - 1'b1;
            end
            TX_STOP: if (bit_end) begin
                if (two_stop_i && st_r.idx == '0) begin
                    st_nxt.idx = 4'h1;
                    st_nxt.cnt = bit_cycles_i - 1'b1;
                end else begin
                    st_nxt.phase = TX_IDLE;
                end
            end
        endcase
        if (st_r.phase == TX_DATA && bit_end && st_r.idx + 1'b1 == data_bits_i)
            st_nxt.idx = '0;
        unique case (st_nxt.phase)
            TX_START: st_nxt.line = 1'b0;
            TX_DATA:  st_nxt.line = st_nxt.shift[0];
            TX_PAR:   st_nxt.line = st_nxt.par;
            default:  st_nxt.line = 1'b1;
        endcase
        if (break_i) st_nxt.line = 1'b0;                     // RULE_18
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r      <= '0;
            st_r.line <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : serial_sender
`default_nettype wire

// ### rtl/serial_line_unit.sv
// Purpose: registers, receiver and interrupts of the serial line unit
// Assumes: bus strobes, straps and bus_initialise are synchronous to ref_clk_i
// Notes:   line and modem inputs pass a two-stage synchroniser
// Contract
// (RULE_01) Block matches when address bits 12..3 equal the address straps.
// (RULE_02) Register chosen by address bits 2 and 1; bit 0 ignored.
// (RULE_03) Offsets 0,2,4,6: receive status, receive buffer, transmit status, buffer.
// (RULE_04) Integrator places console at 177560, others 175610 to 176176.
// (RULE_05) Receive status bit 15: (carrier or clear-to-send) and data-set-ready.
// (RULE_06) Receive status bits 14..8 and 5..1 read zero.
// (RULE_07) Receive done set per character; buffer access or power loss clears it.
// (RULE_08) Receiver interrupt while receive done and its enable are both set.
// (RULE_09) Receive interrupt enable bit 6 read/write, cleared by bus initialise.
// (RULE_10) Writing receive status bit 0 sets reader advance; next start bit clears it.
// (RULE_11) Receive buffer holds right-justified character; bits 15..8 read zero.
// (RULE_12) Strapped vectors answer acknowledges; receiver 60, transmitter 64 by default.
// (RULE_13) Parity generated and checked, even or odd per sense strap; received parity is never checked.
// (RULE_14) Framing-halt strap installed: framing error requests processor halt.
// (RULE_15) All rate straps removed selects 110 baud both ways.
// (RULE_16) Transmit ready bit 7 set when buffer free; interrupt with bit 6.
// (RULE_17) Transmit interrupt enable bit 6 read/write, cleared by bus initialise.
// (RULE_18) Transmit status bit 0 forces space on the line; initialise clears it.
// (RULE_19) Transmit buffer bits 7..0 accepted and sent serially.
// (RULE_20) Frame: start bit, data lsb first, optional parity, one or two stops.
`timescale 1ns/1ns
`default_nettype none
module serial_line_unit
    import slu_pkg::*;
#(
    parameter int CLK_HZ   = CLK_HZ_DEFAULT,
    parameter int TX_DEPTH = 2
) (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic [15:0] bus_wdata_i,
    input  wire logic        bus_rd_i,
    input  wire logic        bus_wr_i,
    output logic [15:0]      bus_rdata_o,
    output logic             bus_ack_o,
    input  wire logic        int_ack_i,
    output logic             irq_rx_o,
    output logic             irq_tx_o,
    output logic [7:0]       vector_o,
    output logic             vector_valid_o,
    input  wire logic        power_ok_i,
    input  wire logic        bus_initialise_i,
    input  wire logic [9:0]  addr_strap_i,
    input  wire logic [4:0]  vector_strap_i,
    input  wire logic        parity_strap_i,
    input  wire logic        parity_sense_strap_i,
    input  wire logic        framing_halt_strap_i,
    input  wire logic        one_stop_strap_i,
    input  wire logic [1:0]  data_bits_strap_i,
    input  wire logic [3:0]  rate_select_strap_i,
    input  wire logic        rxd_i,
    input  wire logic        carrier_i,
    input  wire logic        cts_i,
    input  wire logic        dsr_i,
    output logic             txd_o,
    output logic             reader_advance_o,
    output logic             halt_req_o
);
    generate
        if (CLK_HZ < 100 || TX_DEPTH < 2) begin : g_chk
            $error("serial_line_unit: CLK_HZ or TX_DEPTH out of range");
        end
    endgenerate

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_phase_t;

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        rx_phase_t         phase;
        logic [DIV_W-1:0]  cnt;
        logic [3:0]        idx;
        logic [8:0]        shift;
        logic              par;
        logic [CHAR_W-1:0] rx_data;
        logic              rx_done;
        logic              rx_ie;
        logic              tx_ie;
        logic              brk;
        logic              rdr_adv;
        logic              halt;
        logic [15:0]       rdata;
        logic              ack;
        logic [7:0]        vector;
        logic              vec_valid;
    } slu_state_t;

    slu_state_t        st_r;
    slu_state_t        st_nxt;
    logic              line_rxd;
    logic              modem_ok;
    logic [DIV_W-1:0]  bit_len;
    logic [3:0]        data_bits;
    logic              parity_odd;
    logic              hit;
    logic [2:0]        offs;
    logic              rd_hit;
    logic              wr_hit;
    logic              tx_push;
    logic              tx_space;
    logic [CHAR_W-1:0] tx_char;
    logic              tx_valid;
    logic              tx_take;
    logic              tx_flush;

    // synchronised line and modem levels (second stage only)
    assign line_rxd = st_r.sync2[0];
    assign modem_ok = (st_r.sync2[1] | st_r.sync2[2]) & st_r.sync2[3];   // RULE_05

    // framing configuration from straps (1 = installed)
    assign bit_len    = bit_cycles(rate_select_strap_i, CLK_HZ);          // RULE_15
    assign data_bits  = 4'h5 + {3'h0, ~data_bits_strap_i[0]}
                        + {2'h0, ~data_bits_strap_i[1], 1'b0};
    assign parity_odd = parity_sense_strap_i;                             // RULE_13

    // address decode of the four-word block
    assign hit    = (bus_addr_i[15:13] == IO_PAGE)
                    && (bus_addr_i[12:3] == addr_strap_i);                // RULE_01
    assign offs   = {bus_addr_i[2:1], 1'b0};                              // RULE_02
    assign rd_hit = hit && bus_rd_i;
    assign wr_hit = hit && bus_wr_i;

    // transmit path: a write to the buffer queues one character
    assign tx_push  = wr_hit && (offs == OFF_TX_BUFFER);                  // RULE_19
    assign tx_flush = bus_initialise_i || !power_ok_i;

    char_buffer #(
        .WIDTH (CHAR_W),
        .DEPTH (TX_DEPTH)
    ) u_tx_buffer (
        .ref_clk_i   (ref_clk_i),
        .sys_rst_i   (sys_rst_i),
        .flush_i     (tx_flush),
        .in_data_i   (bus_wdata_i[CHAR_W-1:0]),
        .in_valid_i  (tx_push),
        .in_ready_o  (tx_space),
        .out_data_o  (tx_char),
        .out_valid_o (tx_valid),
        .out_ready_i (tx_take)
    );

    serial_sender u_sender (
        .ref_clk_i    (ref_clk_i),
        .sys_rst_i    (sys_rst_i),
        .bit_cycles_i (bit_len),
        .data_bits_i  (data_bits),
        .parity_en_i  (parity_strap_i),
        .parity_odd_i (parity_odd),
        .two_stop_i   (~one_stop_strap_i),
        .break_i      (st_r.brk),
        .char_i       (tx_char),
        .char_valid_i (tx_valid),
        .char_ready_o (tx_take),
        .txd_o        (txd_o)
    );

    // register outputs
    assign bus_rdata_o      = st_r.rdata;
    assign bus_ack_o        = st_r.ack;
    assign irq_rx_o         = st_r.rx_done && st_r.rx_ie;                 // RULE_08
    assign irq_tx_o         = tx_space && st_r.tx_ie;                     // RULE_16
    assign vector_o         = st_r.vector;
    assign vector_valid_o   = st_r.vec_valid;
    assign reader_advance_o = st_r.rdr_adv;
    assign halt_req_o       = st_r.halt;

    // receiver, register file and interrupt vector logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = {dsr_i, cts_i, carrier_i, rxd_i};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.ack       = rd_hit || wr_hit;
        st_nxt.vec_valid = 1'b0;
        st_nxt.halt      = 1'b0;
        if (st_r.phase != RX_IDLE) st_nxt.cnt = st_r.cnt - 1'b1;

        // clears first so that a same-cycle set below wins
        if (hit && (bus_rd_i || bus_wr_i) && offs == OFF_RX_BUFFER)
            st_nxt.rx_done = 1'b0;                                        // RULE_07
        if (!power_ok_i) st_nxt.rx_done = 1'b0;                           // RULE_07

        // register reads
        if (rd_hit) begin
            st_nxt.rdata = RST_WORD;                                      // RULE_06
            unique case (offs)
                OFF_RX_STATUS: begin
                    st_nxt.rdata[MODEM_BIT] = modem_ok;                   // RULE_05
                    st_nxt.rdata[DONE_BIT]  = st_r.rx_done;
                    st_nxt.rdata[IE_BIT]    = st_r.rx_ie;
                end
                OFF_RX_BUFFER: st_nxt.rdata[CHAR_W-1:0] = st_r.rx_data;   // RULE_11
                OFF_TX_STATUS: begin
                    st_nxt.rdata[DONE_BIT] = tx_space;                    // RULE_16
                    st_nxt.rdata[IE_BIT]   = st_r.tx_ie;
                    st_nxt.rdata[BRK_BIT]  = st_r.brk;
                end
                default: st_nxt.rdata = RST_WORD;
            endcase
        end

        // register writes
        if (wr_hit && offs == OFF_RX_STATUS) begin                        // RULE_03
            st_nxt.rx_ie = bus_wdata_i[IE_BIT];                           // RULE_09
            if (bus_wdata_i[RDR_BIT]) st_nxt.rdr_adv = 1'b1;              // RULE_10
        end
        if (wr_hit && offs == OFF_TX_STATUS) begin
            st_nxt.tx_ie = bus_wdata_i[IE_BIT];                           // RULE_17
            st_nxt.brk   = bus_wdata_i[BRK_BIT];                          // RULE_18
        end

        // receiver: half-bit start check, then mid-bit samples
        unique case (st_r.phase)
            RX_IDLE: if (!line_rxd) begin
                st_nxt.phase = RX_START;
                st_nxt.cnt   = {1'b0, bit_len[DIV_W-1:1]};
                if (!(wr_hit && offs == OFF_RX_STATUS))
                    st_nxt.rdr_adv = 1'b0;                                // RULE_10
            end
            RX_START: if (st_r.cnt == '0) begin
                st_nxt.phase = line_rxd ? RX_IDLE : RX_DATA;
                st_nxt.cnt   = bit_len - 1'b1;
                st_nxt.idx   = '0;
                st_nxt.shift = '0;
                st_nxt.par   = parity_odd;
            end
            RX_DATA: if (st_r.cnt == '0) begin
                st_nxt.shift[st_r.idx] = line_rxd;                        // RULE_20
                st_nxt.par = st_r.par ^ line_rxd;
                st_nxt.idx = st_r.idx + 1'b1;
                st_nxt.cnt = bit_len - 1'b1;
                if (st_r.idx + 1'b1 == data_bits)
                    st_nxt.phase = parity_strap_i ? RX_PAR : RX_STOP;
            end
            RX_PAR: if (st_r.cnt == '0) begin
                st_nxt.shift[st_r.idx] = line_rxd;                        // RULE_11
                st_nxt.par   = st_r.par ^ line_rxd;                       // RULE_13
                st_nxt.phase = RX_STOP;
                st_nxt.cnt   = bit_len - 1'b1;
            end
            RX_STOP: if (st_r.cnt == '0) begin
                st_nxt.phase   = RX_IDLE;
                st_nxt.rx_data = st_r.shift[CHAR_W-1:0];
                st_nxt.rx_done = 1'b1;                                    // RULE_07
                if (!line_rxd && framing_halt_strap_i)
                    st_nxt.halt = 1'b1;                                   // RULE_14
            end
        endcase

        // interrupt acknowledge: receiver ahead of transmitter
        if (int_ack_i && (irq_rx_o || irq_tx_o)) begin
            st_nxt.vector    = {vector_strap_i, 3'h0};                    // RULE_12
            st_nxt.vector[VEC_TX_BIT] = !irq_rx_o;                        // RULE_12
            st_nxt.vec_valid = 1'b1;
        end

        // bus initialise clears the software enables and break
        if (bus_initialise_i) begin
            st_nxt.rx_ie = RST_IE;                                        // RULE_09
            st_nxt.tx_ie = RST_IE;                                        // RULE_17
            st_nxt.brk   = RST_BRK;                                       // RULE_18
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r       <= '0;
            st_r.sync1 <= '1;
            st_r.sync2 <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : serial_line_unit
`default_nettype wire

// ### testbench/echo_terminal.sv
// Purpose: far-side terminal model that echoes every frame
// Assumes: one serial line each way
// Notes:   line is always driven, idle mark
`timescale 1ns/1ns
`default_nettype none
module echo_terminal (
    input  wire logic txd_i,
    output logic      rxd_o
);
    // frames come back bit for bit
    assign rxd_o = txd_i;
endmodule : echo_terminal
`default_nettype wire

// ### testbench/slu_checker_properties.sv
// Purpose: port-level properties of the serial line unit
// Assumes: single clock domain
// Notes:   bound into the design
`timescale 1ns/1ns
`default_nettype none
module slu_checker
    import slu_pkg::*;
(
    input wire logic        ref_clk_i, sys_rst_i, bus_rd_i, bus_wr_i, bus_ack_o,
    input wire logic        int_ack_i, irq_rx_o, irq_tx_o, vector_valid_o, bus_initialise_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic [15:0] bus_rdata_o,
    input wire logic [7:0]  vector_o,
    input wire logic [9:0]  addr_strap_i,
    input wire logic [4:0]  vector_strap_i
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // block decode and register select
    wire logic hit = bus_addr_i[15:13] == IO_PAGE && bus_addr_i[12:3] == addr_strap_i;
    wire logic req = (bus_rd_i || bus_wr_i) && hit;
    wire logic irq = irq_rx_o || irq_tx_o;
    property p_ack; req |=> bus_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack after hit");
    property p_miss; !req |=> !bus_ack_o; endproperty
    a_miss: assert property (p_miss) else $error("ack without hit");
    property p_rxs; bus_rd_i && hit && bus_addr_i[2:1] == OFF_RX_STATUS[2:1]
        |=> (bus_rdata_o & 16'h7f3f) == 16'h0; endproperty
    a_rxs: assert property (p_rxs) else $error("rx status unused bits");
    property p_rxb; bus_rd_i && hit && bus_addr_i[2:1] == OFF_RX_BUFFER[2:1]
        |=> bus_rdata_o[15:8] == 8'h0 && !irq_rx_o; endproperty
    a_rxb: assert property (p_rxb) else $error("rx buffer read");
    property p_txs; bus_rd_i && hit && bus_addr_i[2:1] == OFF_TX_STATUS[2:1]
        |=> (bus_rdata_o & 16'hff3e) == 16'h0; endproperty
    a_txs: assert property (p_txs) else $error("tx status unused bits");
    property p_vec; int_ack_i && irq |=> vector_valid_o
        && vector_o == {$past(vector_strap_i), !$past(irq_rx_o), 2'b00}; endproperty
    a_vec: assert property (p_vec) else $error("wrong vector");
    property p_novec; !(int_ack_i && irq) |=> !vector_valid_o; endproperty
    a_novec: assert property (p_novec) else $error("vector without request");
    property p_init; bus_initialise_i |=> !irq_rx_o && !irq_tx_o; endproperty
    a_init: assert property (p_init) else $error("enable kept over init");
endmodule : slu_checker
bind serial_line_unit slu_checker u_chk (.*);
`default_nettype wire

// ### testbench/serial_line_unit_tb.sv
// Purpose: self-checking bench of the serial line unit
// Assumes: echo terminal on the line, 18 clocks per bit
// Notes:   reads queue their expected word, a monitor compares at ack
`timescale 1ns/1ns
`default_nettype none
module serial_line_unit_tb;
    import slu_pkg::*;
    logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, bus_rd_i = 1'b0, bus_wr_i = 1'b0, was_rd = 1'b0;
    logic int_ack_i = 1'b0, bus_initialise_i = 1'b0, carrier_i = 1'b0, cts_i = 1'b0;
    logic dsr_i = 1'b0, parity_strap_i = 1'b0, parity_sense_strap_i = 1'b0;
    logic [15:0] bus_addr_i = 16'h0, bus_wdata_i = 16'h0, base, exp_w, exp_q[$];
    logic [9:0]  addr_strap_i = 10'h0;
    logic [1:0]  data_bits_strap_i = 2'h0;
    logic [7:0]  c;
    wire logic [15:0] bus_rdata_o;
    wire logic [7:0]  vector_o;
    wire logic bus_ack_o, irq_rx_o, irq_tx_o, vector_valid_o, txd_o, rxd_i;
    wire logic reader_advance_o, halt_req_o;
    wire logic power_ok_i = 1'b1, framing_halt_strap_i = 1'b1, one_stop_strap_i = 1'b1;
    wire logic [4:0] vector_strap_i = 5'h06;
    wire logic [3:0] rate_select_strap_i = 4'h0;
    int cmp_count = 0, mismatches = 0, cycles = 0, halts = 0;
    // clock
    always #25 ref_clk_i = ~ref_clk_i;
    serial_line_unit #(.CLK_HZ(2000)) u_dut (.*);
    echo_terminal u_term (.txd_i(txd_o), .rxd_o(rxd_i));
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task check(input logic [15:0] got, input logic [15:0] want);
        cmp_count++;
        if (got !== want) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check
    // one-cycle strobe, launched and dropped on falling edges
    task acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(negedge ref_clk_i);
        bus_rd_i = !w;
        bus_wr_i = w;
        bus_addr_i = a;
        bus_wdata_i = d;
        @(negedge ref_clk_i);
        bus_rd_i = 1'b0;
        bus_wr_i = 1'b0;
    endtask : acc
    task rd(input logic [15:0] a, input logic [15:0] want);
        exp_q.push_back(want);
        acc(1'b0, a, 16'h0);
    endtask : rd
    task iack(input logic [7:0] want);
        @(negedge ref_clk_i);
        int_ack_i = 1'b1;
        @(negedge ref_clk_i);
        int_ack_i = 1'b0;
        check({8'h0, vector_o}, {8'h0, want});
    endtask : iack
    always @(posedge ref_clk_i) was_rd <= bus_rd_i;
    // monitor on falling edges: read data against oldest note, halt pulses, hang limit
    always @(negedge ref_clk_i) begin
        if (bus_ack_o === 1'b1 && was_rd) check(bus_rdata_o, exp_q.pop_front());
        if (halt_req_o === 1'b1) halts++;
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'hf18f));
        addr_strap_i = 10'h3ee;
        base = {3'h7, addr_strap_i, 3'h0};
        repeat (5) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        // modem status combinations, odd addresses alias
        for (int i = 0; i < 8; i++) begin
            {carrier_i, cts_i, dsr_i} = 3'(i);
            repeat (4) @(negedge ref_clk_i);
            rd(base | 16'(i & 1), {(carrier_i | cts_i) & dsr_i, 15'h0});
        end
        rd(base | 16'h4, 16'h0080);
        rd(base | 16'h6, 16'h0000);
        acc(1'b0, base ^ 16'h8000, 16'h0);
        $display("test 1 done");
        acc(1'b1, base, 16'h0041);
        acc(1'b1, base | 16'h4, 16'h0040);
        check({15'h0, reader_advance_o}, 16'h1);
        check({15'h0, irq_tx_o}, 16'h1);
        rd(base, 16'h8040);
        $display("test 2 done");
        // echoed characters: 8 bits plain, 7 bits even, 7 bits odd
        for (int k = 0; k < 3; k++) begin
            c = 8'($urandom);
            parity_strap_i = (k != 0);
            parity_sense_strap_i = (k == 2);
            data_bits_strap_i = (k != 0) ? 2'h1 : 2'h0;
            exp_w = (k == 0) ? {8'h0, c} : {8'h0, (^c[6:0]) ^ (k == 2), c[6:0]};
            acc(1'b1, base | 16'h6, {8'($urandom), c});
            for (int n = 0; n < 600 && irq_rx_o !== 1'b1; n++) @(negedge ref_clk_i);
            check({15'h0, reader_advance_o}, 16'h0);
            iack(8'h30);
            rd(base, 16'h80c0);
            rd(base | 16'h2, exp_w);
        end
        iack(8'h34);
        $display("test 3 done");
        // break is echoed as an all-space frame with a framing error
        acc(1'b1, base | 16'h4, 16'h0001);
        repeat (300) @(negedge ref_clk_i);
        check({15'h0, txd_o}, 16'h0);
        check(16'(halts != 0), 16'h1);
        rd(base | 16'h4, 16'h0081);
        @(negedge ref_clk_i);
        bus_initialise_i = 1'b1;
        @(negedge ref_clk_i);
        bus_initialise_i = 1'b0;
        rd(base | 16'h4, 16'h0080);
        rd(base, 16'h8080);
        rd(base | 16'h2, 16'h0000);
        repeat (3) @(negedge ref_clk_i);
        check(16'(exp_q.size()), 16'h0);
        $display("test 4 done");
        test_done();
    end
endmodule : serial_line_unit_tb
`default_nettype wire
